//--- hdl/dasp_pkg.sv
// Shared constants of the accumulator, round, store clipping and shifter datapath.
// Notes on behaviour
// - 40-bit adder; subtract feeds complement with carry.
// - Guard flag set when bits 39..32 differ.
// - Guard flag plus its enable raises trap.
// - Clip flags only set by hardware, cleared by software.
// - Unclipped mode: clip event plus enable raises trap.
// - Status bits OR both guard and both clip flags.
// - 40-bit clipping loads 9.31 limits, sets flag.
// - 32-bit clipping loads 1.31 limits, no guard flag.
// - Catastrophic mode wraps; bit-39 overflow sets flag.
// - Clip decision uses sum, overflow, control bits.
// - Multiply-accumulate ops may write back other accumulator.
// - Write-back to pointer, or memory then pointer+2.
// - Rounding mode bit; unrounded stores truncate.
// - Conventional rounding adds bit 15 to high word.
// - Convergent: exact half rounds up only if odd.
// - Store clipping forces 0x7FFF above 0x007FFF.
// - Store clipping forces 0x8000 below 0xFF8000.
// - Store clipping never changes the accumulator.
// - Store clipping off passes value unchanged.
// - Shifter: right up to 31, left up to 32.
// - Signed amount: positive right, negative left.
// - 40-bit shifter; X data placed by direction.
// - Adder selects one of two accumulators.
package dasp_pkg;
  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int EXT_W = 25;
  localparam int SHIFT_W = 6;
  localparam int SIGN_BIT = 39;
  localparam int GUARD_LSB = 32;
  localparam int FRAC_SIGN_BIT = 31;
  localparam int HI_LSB = 16;
  localparam int ROUND_BIT = 15;
  localparam int XR_LSB = 16;
  localparam int CTL_CLIP_A_BIT = 7;
  localparam int CTL_CLIP_B_BIT = 6;
  localparam int CTL_STORE_CLIP_BIT = 5;
  localparam int CTL_WIDTH_BIT = 4;
  localparam int CTL_ROUND_MODE_BIT = 1;
  localparam logic [39:0] MAX_40 = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] MIN_40 = 40'h80_0000_0000;
  localparam logic [39:0] MAX_32 = 40'h00_7FFF_FFFF;
  localparam logic [39:0] MIN_32 = 40'hFF_8000_0000;
  localparam logic [15:0] LOW_TIE = 16'h8000;
  localparam logic [15:0] STORE_MAX = 16'h7FFF;
  localparam logic [15:0] STORE_MIN = 16'h8000;
  localparam logic [24:0] STORE_POS_LIMIT = 25'h000_7FFF;
  localparam logic [24:0] STORE_NEG_LIMIT = 25'h1FF_8000;
  localparam logic [15:0] PTR_STEP = 16'h0002;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_MULACC = 3'h1;
  localparam logic [2:0] OP_MUL_ONLY = 3'h2;
  localparam logic [2:0] OP_NEG_MUL = 3'h3;
  localparam logic [2:0] OP_DIST = 3'h4;
  localparam logic [2:0] OP_ACC_DIST = 3'h5;
  localparam logic [1:0] SRC_ACC_A = 2'h0;
  localparam logic [1:0] SRC_ACC_B = 2'h1;
  localparam logic [1:0] SRC_XBUS = 2'h2;
endpackage

//--- hdl/dasp_shifter.sv
// Registered 40-bit bidirectional barrel shifter.
`timescale 1ns/1ps
`default_nettype none
module dasp_shifter
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [1:0] i_src_sel,
  input wire logic signed [dasp_pkg::SHIFT_W-1:0] i_amount,
  input wire logic i_arith,
  input wire logic [dasp_pkg::ACC_W-1:0] i_acc_a,
  input wire logic [dasp_pkg::ACC_W-1:0] i_acc_b,
  input wire logic [dasp_pkg::WORD_W-1:0] i_xbus_data,
  output logic o_valid,
  output logic [dasp_pkg::ACC_W-1:0] o_result,
  output logic [dasp_pkg::WORD_W-1:0] o_mcu_result
);
  localparam int AW = dasp_pkg::ACC_W;
  localparam int WW = dasp_pkg::WORD_W;
  typedef struct packed {
    logic valid;
    logic [AW-1:0] result;
    logic [WW-1:0] mcu;
  } dasp_shift_state_s;
  dasp_shift_state_s st;
  dasp_shift_state_s next_st;
  logic [AW-1:0] operand;
  logic [AW-1:0] shifted;
  logic [dasp_pkg::SHIFT_W-1:0] mag;
  logic right;

  always_comb
  begin
    next_st = st;
    right = !i_amount[dasp_pkg::SHIFT_W-1];
    mag = right ? i_amount : -i_amount;
    case (i_src_sel)
      dasp_pkg::SRC_ACC_A: operand = i_acc_a;
      dasp_pkg::SRC_ACC_B: operand = i_acc_b;
      default:
      begin
        if (right)
          operand = {{(AW-WW-dasp_pkg::XR_LSB){i_xbus_data[WW-1]}}, i_xbus_data,
                     {dasp_pkg::XR_LSB{1'b0}}};
        else
          operand = {{(AW-WW){i_xbus_data[WW-1]}}, i_xbus_data};
      end
    endcase
    if (!right)
      shifted = operand << mag;
    else if (i_arith)
      shifted = AW'($signed(operand) >>> mag);
    else
      shifted = operand >> mag;
    next_st.valid = i_valid;
    if (i_valid)
    begin
      next_st.result = shifted;
      next_st.mcu = right ? shifted[dasp_pkg::XR_LSB+WW-1:dasp_pkg::XR_LSB] : shifted[WW-1:0];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_valid = st.valid;
  assign o_result = st.result;
  assign o_mcu_result = st.mcu;
endmodule
`default_nettype wire

//--- hdl/dasp_core.sv
// Accumulator adder, clipping, flags, rounding, store clipping and write-back.
`timescale 1ns/1ps
`default_nettype none
module dasp_core
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_core_control_reg,
  input wire logic i_accum_a_guard_trap_enable,
  input wire logic i_accum_b_guard_trap_enable,
  input wire logic i_catastrophic_trap_enable,
  input wire logic i_op_valid,
  input wire logic i_op_target_b,
  input wire logic i_op_subtract,
  input wire logic i_op_zero_acc,
  input wire logic [dasp_pkg::ACC_W-1:0] i_op_operand,
  input wire logic [2:0] i_op_kind,
  input wire logic i_op_writeback,
  input wire logic i_op_wb_indirect,
  input wire logic i_store_valid,
  input wire logic i_store_acc_b,
  input wire logic i_store_round,
  input wire logic [15:0] i_store_addr,
  input wire logic i_clip_clear_a,
  input wire logic i_clip_clear_b,
  input wire logic i_ptr_load,
  input wire logic [15:0] i_ptr_data,
  input wire logic i_shift_valid,
  input wire logic [1:0] i_shift_src,
  input wire logic signed [dasp_pkg::SHIFT_W-1:0] i_shift_amount,
  input wire logic i_shift_arith,
  input wire logic [dasp_pkg::WORD_W-1:0] i_xbus_rd_data,
  output logic [dasp_pkg::ACC_W-1:0] o_acc_a,
  output logic [dasp_pkg::ACC_W-1:0] o_acc_b,
  output logic o_accum_a_guard_ovf_flag,
  output logic o_accum_b_guard_ovf_flag,
  output logic o_accum_a_clip_flag,
  output logic o_accum_b_clip_flag,
  output logic o_either_guard_ovf_flag,
  output logic o_either_clip_flag,
  output logic o_arith_trap_req,
  output logic [15:0] o_writeback_pointer_reg,
  output logic o_xbus_wr_valid,
  output logic [15:0] o_xbus_wr_addr,
  output logic [dasp_pkg::WORD_W-1:0] o_xbus_wr_data,
  output logic o_shift_valid,
  output logic [dasp_pkg::ACC_W-1:0] o_shift_result,
  output logic [dasp_pkg::WORD_W-1:0] o_shift_mcu_result
);
  localparam int AW = dasp_pkg::ACC_W;
  localparam int WW = dasp_pkg::WORD_W;
  localparam int XW = dasp_pkg::EXT_W;
  localparam int MSB = dasp_pkg::SIGN_BIT;
  localparam int GL = dasp_pkg::GUARD_LSB;
  localparam int FS = dasp_pkg::FRAC_SIGN_BIT;
  localparam int HL = dasp_pkg::HI_LSB;
  localparam int RB = dasp_pkg::ROUND_BIT;

  typedef struct packed {
    logic [AW-1:0] acc_a;
    logic [AW-1:0] acc_b;
    logic ovf_a;
    logic ovf_b;
    logic clip_a;
    logic clip_b;
    logic any_ovf;
    logic any_clip;
    logic trap;
    logic [15:0] wb_ptr;
    logic wr_valid;
    logic [15:0] wr_addr;
    logic [WW-1:0] wr_data;
  } dasp_core_state_s;

  dasp_core_state_s st;
  dasp_core_state_s next_st;

  logic [AW-1:0] acc_src;
  logic [AW-1:0] lhs;
  logic [AW-1:0] rhs;
  logic [AW:0] sum;
  logic [AW-1:0] res;
  logic [AW-1:0] clip_val;
  logic sum_neg;
  logic ovf39;
  logic ovf31;
  logic guard_mis;
  logic clip_en;
  logic mode32;
  logic clip_hit;
  logic new_guard;
  logic cat_event;
  logic conv;
  logic store_en;
  logic wb_ok;
  logic [AW-1:0] wb_acc;
  logic [XW-1:0] wb_ext;
  logic [WW-1:0] wb_data;
  logic [AW-1:0] store_acc;
  logic [XW-1:0] store_ext;
  logic [WW-1:0] store_raw;
  logic [WW-1:0] store_data;
  logic [WW-1:0] store_hi;

  // Rounded or truncated high word, kept sign-extended for the clipping test.
  function automatic logic [XW-1:0] round_ext(logic [AW-1:0] a, logic do_round, logic cv);
    logic tie;
    logic inc;
    tie = (a[HL-1:0] == dasp_pkg::LOW_TIE);
    inc = do_round && a[RB] && !(cv && tie && !a[HL]);
    return {a[MSB], a[MSB:HL]} + XW'(inc);
  endfunction

  // Clipping of the word that goes to data memory; the accumulator is untouched.
  function automatic logic [WW-1:0] store_clip(logic [XW-1:0] v, logic neg, logic en);
    logic [WW-1:0] r;
    r = v[WW-1:0];
    if (en && !neg && ($signed(v) > $signed(dasp_pkg::STORE_POS_LIMIT)))
      r = dasp_pkg::STORE_MAX;
    if (en && neg && ($signed(v) < $signed(dasp_pkg::STORE_NEG_LIMIT)))
      r = dasp_pkg::STORE_MIN;
    return r;
  endfunction

  always_comb
  begin
    next_st = st;
    acc_src = i_op_target_b ? st.acc_b : st.acc_a;
    lhs = i_op_zero_acc ? '0 : acc_src;
    rhs = i_op_subtract ? ~i_op_operand : i_op_operand;
    // Subtraction adds the complement with the carry held high (no borrow).
    sum = {lhs[MSB], lhs} + {rhs[MSB], rhs} + (AW+1)'(i_op_subtract);
    res = sum[AW-1:0];
    sum_neg = sum[AW];
    ovf39 = sum[AW] ^ sum[MSB];
    guard_mis = (|res[MSB:GL]) && !(&res[MSB:GL]);
    ovf31 = ovf39 || ((|res[MSB:FS]) && !(&res[MSB:FS]));
    clip_en = i_op_target_b ? i_core_control_reg[dasp_pkg::CTL_CLIP_B_BIT]
                            : i_core_control_reg[dasp_pkg::CTL_CLIP_A_BIT];
    mode32 = clip_en && !i_core_control_reg[dasp_pkg::CTL_WIDTH_BIT];
    clip_hit = mode32 ? ovf31 : ovf39;
    if (clip_en && clip_hit && mode32)
      clip_val = sum_neg ? dasp_pkg::MIN_32 : dasp_pkg::MAX_32;
    else if (clip_en && clip_hit)
      clip_val = sum_neg ? dasp_pkg::MIN_40 : dasp_pkg::MAX_40;
    else
      clip_val = res;
    new_guard = guard_mis && !mode32;
    cat_event = i_op_valid && !clip_en && ovf39;

    if (i_op_valid && i_op_target_b)
    begin
      next_st.acc_b = clip_val;
      next_st.ovf_b = new_guard;
    end
    else if (i_op_valid)
    begin
      next_st.acc_a = clip_val;
      next_st.ovf_a = new_guard;
    end
    // A new clip event wins over a software clear in the same cycle.
    next_st.clip_a = (st.clip_a && !i_clip_clear_a)
                     || (i_op_valid && !i_op_target_b && clip_hit);
    next_st.clip_b = (st.clip_b && !i_clip_clear_b)
                     || (i_op_valid && i_op_target_b && clip_hit);
    next_st.any_ovf = next_st.ovf_a || next_st.ovf_b;
    next_st.any_clip = next_st.clip_a || next_st.clip_b;
    next_st.trap = (next_st.ovf_a && i_accum_a_guard_trap_enable)
                   || (next_st.ovf_b && i_accum_b_guard_trap_enable)
                   || (cat_event && i_catastrophic_trap_enable);

    conv = i_core_control_reg[dasp_pkg::CTL_ROUND_MODE_BIT];
    store_en = i_core_control_reg[dasp_pkg::CTL_STORE_CLIP_BIT];
    wb_ok = i_op_valid && i_op_writeback && (i_op_kind == dasp_pkg::OP_MULACC);
    wb_acc = i_op_target_b ? st.acc_a : st.acc_b;
    wb_ext = round_ext(wb_acc, 1'b1, conv);
    wb_data = store_clip(wb_ext, wb_acc[MSB], store_en);
    store_acc = i_store_acc_b ? st.acc_b : st.acc_a;
    store_hi = store_acc[HL+WW-1:HL];
    store_ext = round_ext(store_acc, i_store_round, conv);
    store_raw = store_ext[WW-1:0];
    store_data = store_clip(store_ext, store_acc[MSB], store_en);

    next_st.wr_valid = 1'b0;
    if (wb_ok && !i_op_wb_indirect)
      next_st.wb_ptr = wb_data;
    else if (wb_ok && !i_store_valid)
    begin
      next_st.wr_valid = 1'b1;
      next_st.wr_addr = st.wb_ptr;
      next_st.wr_data = wb_data;
      next_st.wb_ptr = st.wb_ptr + dasp_pkg::PTR_STEP;
    end
    else if (i_ptr_load)
      next_st.wb_ptr = i_ptr_data;
    if (i_store_valid)
    begin
      next_st.wr_valid = 1'b1;
      next_st.wr_addr = i_store_addr;
      next_st.wr_data = store_data;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  dasp_shifter u_shifter
  (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(i_shift_valid),
    .i_src_sel(i_shift_src),
    .i_amount(i_shift_amount),
    .i_arith(i_shift_arith),
    .i_acc_a(st.acc_a),
    .i_acc_b(st.acc_b),
    .i_xbus_data(i_xbus_rd_data),
    .o_valid(o_shift_valid),
    .o_result(o_shift_result),
    .o_mcu_result(o_shift_mcu_result)
  );

  assign o_acc_a = st.acc_a;
  assign o_acc_b = st.acc_b;
  assign o_accum_a_guard_ovf_flag = st.ovf_a;
  assign o_accum_b_guard_ovf_flag = st.ovf_b;
  assign o_accum_a_clip_flag = st.clip_a;
  assign o_accum_b_clip_flag = st.clip_b;
  assign o_either_guard_ovf_flag = st.any_ovf;
  assign o_either_clip_flag = st.any_clip;
  assign o_arith_trap_req = st.trap;
  assign o_writeback_pointer_reg = st.wb_ptr;
  assign o_xbus_wr_valid = st.wr_valid;
  assign o_xbus_wr_addr = st.wr_addr;
  assign o_xbus_wr_data = st.wr_data;

  default clocking dasp_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sum_wrap_a: assert property (
    i_op_valid && !i_op_target_b && !clip_en && !i_op_zero_acc && !i_op_subtract
    |=> o_acc_a == $past(o_acc_a) + $past(i_op_operand))
    else $error("Accumulator A is not the plain sum.");

  guard_flag_a: assert property (
    i_op_valid && !i_op_target_b && !mode32
    |=> o_accum_a_guard_ovf_flag == $past(guard_mis))
    else $error("Guard flag of accumulator A does not follow the sum.");

  guard_trap_a: assert property (
    i_op_valid && !i_op_target_b && !mode32 && guard_mis && i_accum_a_guard_trap_enable
    |=> o_arith_trap_req)
    else $error("Guard overflow with enable gave no trap.");

  clip_sticky_a: assert property (
    o_accum_a_clip_flag && !i_clip_clear_a |=> o_accum_a_clip_flag)
    else $error("Clip flag of accumulator A dropped without a clear.");

  cat_trap_a: assert property (
    cat_event && i_catastrophic_trap_enable |=> o_arith_trap_req && o_either_clip_flag)
    else $error("Catastrophic overflow gave no trap.");

  either_flags_a: assert property (
    o_either_clip_flag == (o_accum_a_clip_flag || o_accum_b_clip_flag)
    && o_either_guard_ovf_flag == (o_accum_a_guard_ovf_flag || o_accum_b_guard_ovf_flag))
    else $error("Combined status bits disagree with the flags.");

  super_clip_a: assert property (
    i_op_valid && !i_op_target_b && clip_en && !mode32 && ovf39
    |=> o_acc_a == ($past(sum_neg) ? dasp_pkg::MIN_40 : dasp_pkg::MAX_40)
        && o_accum_a_clip_flag)
    else $error("40-bit clipping loaded the wrong limit.");

  frac_clip_b_a: assert property (
    i_op_valid && i_op_target_b && mode32 && ovf31
    |=> o_acc_b == ($past(sum_neg) ? dasp_pkg::MIN_32 : dasp_pkg::MAX_32)
        && o_accum_b_clip_flag && !o_accum_b_guard_ovf_flag)
    else $error("32-bit clipping loaded the wrong limit.");

  wrap_mode_b_a: assert property (
    i_op_valid && i_op_target_b && !clip_en
    |=> o_acc_b == $past(res) && (o_accum_b_clip_flag || !$past(ovf39)))
    else $error("Catastrophic mode did not wrap or flag.");

  wb_post_inc_a: assert property (
    wb_ok && i_op_wb_indirect && !i_store_valid
    |=> o_xbus_wr_valid && o_xbus_wr_addr == $past(o_writeback_pointer_reg)
        && o_writeback_pointer_reg == $past(o_writeback_pointer_reg) + dasp_pkg::PTR_STEP)
    else $error("Indirect write-back address or increment wrong.");

  conv_tie_a: assert property (
    i_store_valid && i_store_round && conv && !store_en
    && store_acc[HL-1:0] == dasp_pkg::LOW_TIE && !store_acc[HL]
    |=> o_xbus_wr_data == $past(store_hi))
    else $error("Convergent rounding moved an even tie.");

  store_pos_a: assert property (
    i_store_valid && store_en && !store_acc[MSB]
    && $signed(store_ext) > $signed(dasp_pkg::STORE_POS_LIMIT)
    |=> o_xbus_wr_data == dasp_pkg::STORE_MAX)
    else $error("Positive store value was not clipped.");

  store_neg_a: assert property (
    i_store_valid && store_en && store_acc[MSB]
    && $signed(store_ext) < $signed(dasp_pkg::STORE_NEG_LIMIT)
    |=> o_xbus_wr_data == dasp_pkg::STORE_MIN)
    else $error("Negative store value was not clipped.");

  store_keeps_acc_a: assert property (
    i_store_valid && !i_op_valid
    |=> o_acc_a == $past(o_acc_a) && o_acc_b == $past(o_acc_b))
    else $error("A store changed an accumulator.");

  store_pass_a: assert property (
    i_store_valid && !store_en |=> o_xbus_wr_valid && o_xbus_wr_data == $past(store_raw))
    else $error("Store value altered with clipping off.");

  clip_sticky_b_a: assert property (
    o_accum_b_clip_flag && !i_clip_clear_b |=> o_accum_b_clip_flag)
    else $error("Clip flag of accumulator B dropped without a clear.");

  wb_direct_a: assert property (
    wb_ok && !i_op_wb_indirect && !i_store_valid
    |=> o_writeback_pointer_reg == $past(wb_data) && !o_xbus_wr_valid)
    else $error("Direct write-back did not load the pointer.");

  shift_zero_a: assert property (
    i_shift_valid && i_shift_amount == '0 && i_shift_src == dasp_pkg::SRC_ACC_A
    |=> o_shift_valid && o_shift_result == $past(o_acc_a))
    else $error("Shift by zero changed the operand.");

  cov_super_clip: cover property (i_op_valid && clip_en && !mode32 && ovf39);
  cov_store_clip: cover property (i_store_valid && store_en && store_data != store_raw);
  cov_wb_indirect: cover property (wb_ok && i_op_wb_indirect ##1 o_xbus_wr_valid);
  cov_trap: cover property (o_arith_trap_req);
endmodule
`default_nettype wire

//--- verif/dasp_xbus_mem.sv
// Data memory model on the X bus side of the accumulator datapath.
`timescale 1ns/1ps
`default_nettype none
module dasp_xbus_mem
(
  input wire logic i_clk_sys,
  input wire logic i_wr_valid,
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [15:0] i_rd_addr,
  output logic [15:0] o_rd_data
);
  logic [15:0] mem [0:255];
  // Word writes land on even addresses, so bit 0 is not part of the index.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_wr_valid)
    begin
      mem[i_wr_addr[8:1]] <= i_wr_data;
    end
  end
  assign o_rd_data = mem[i_rd_addr[8:1]];
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking testbench of the accumulator, store and shifter datapath.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, op_v, op_tb, op_sub, op_zero, op_wb, op_ind, s_v, s_b, s_r;
  logic gte_a, gte_b, cte, clr_a, clr_b, p_ld, sh_v, sh_ar;
  logic [15:0] ctl, s_addr, p_data, xrd, rd_addr, wr_addr, wr_data, ptr, mcu;
  logic [2:0] kind;
  logic [1:0] sh_src;
  logic signed [5:0] sh_amt;
  logic [39:0] opd, acc_a, acc_b, sh_res;
  logic ga, gb, ca, cb, eg, ec, trap, wr_v, sh_ov;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  dasp_core DUT
  (
    .i_clk_sys(clk), .i_rst(rst), .i_core_control_reg(ctl),
    .i_accum_a_guard_trap_enable(gte_a), .i_accum_b_guard_trap_enable(gte_b),
    .i_catastrophic_trap_enable(cte), .i_op_valid(op_v), .i_op_target_b(op_tb),
    .i_op_subtract(op_sub), .i_op_zero_acc(op_zero), .i_op_operand(opd),
    .i_op_kind(kind), .i_op_writeback(op_wb), .i_op_wb_indirect(op_ind),
    .i_store_valid(s_v), .i_store_acc_b(s_b), .i_store_round(s_r),
    .i_store_addr(s_addr), .i_clip_clear_a(clr_a), .i_clip_clear_b(clr_b),
    .i_ptr_load(p_ld), .i_ptr_data(p_data), .i_shift_valid(sh_v),
    .i_shift_src(sh_src), .i_shift_amount(sh_amt), .i_shift_arith(sh_ar),
    .i_xbus_rd_data(xrd), .o_acc_a(acc_a), .o_acc_b(acc_b),
    .o_accum_a_guard_ovf_flag(ga), .o_accum_b_guard_ovf_flag(gb),
    .o_accum_a_clip_flag(ca), .o_accum_b_clip_flag(cb),
    .o_either_guard_ovf_flag(eg), .o_either_clip_flag(ec),
    .o_arith_trap_req(trap), .o_writeback_pointer_reg(ptr),
    .o_xbus_wr_valid(wr_v), .o_xbus_wr_addr(wr_addr), .o_xbus_wr_data(wr_data),
    .o_shift_valid(sh_ov), .o_shift_result(sh_res), .o_shift_mcu_result(mcu)
  );

  dasp_xbus_mem mem_model
  (
    .i_clk_sys(clk), .i_wr_valid(wr_v), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_rd_addr(rd_addr), .o_rd_data(xrd)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim;
    end
  end

  // One adder operation; results are settled at the falling edge on return.
  task automatic op(input logic tb, input logic sub, input logic zero, input logic [39:0] v);
    @(negedge clk);
    op_tb = tb;
    op_sub = sub;
    op_zero = zero;
    opd = v;
    op_v = 1'b1;
    @(negedge clk);
    op_v = 1'b0;
  endtask

  task automatic st(input logic r, input logic [15:0] a);
    s_r = r;
    s_addr = a;
    s_v = 1'b1;
    @(negedge clk);
    s_v = 1'b0;
  endtask

  task clr;
    clr_a = 1'b1;
    clr_b = 1'b1;
    @(negedge clk);
    clr_a = 1'b0;
    clr_b = 1'b0;
  endtask

  task t_catas;
    chk("acc_a", acc_a, 40'h00_0000_0000);
    chk("ptr", ptr, 16'h0000);
    gte_a = 1'b1;
    cte = 1'b1;
    op(1'b0, 1'b0, 1'b1, 40'h7F_FFFF_FFFF);
    chk("guard_a", ga, 1'b1);
    chk("trap", trap, 1'b1);
    chk("either_guard", eg, 1'b1);
    gte_a = 1'b0;
    op(1'b0, 1'b0, 1'b0, 40'h00_0000_0001);
    chk("acc_a", acc_a, 40'h80_0000_0000);
    chk("clip_a", ca, 1'b1);
    chk("trap", trap, 1'b1);
    chk("either_clip", ec, 1'b1);
    @(negedge clk);
    chk("trap", trap, 1'b0);
    cte = 1'b0;
    op(1'b0, 1'b0, 1'b1, 40'h00_0000_0004);
    chk("guard_a", ga, 1'b0);
    chk("clip_a", ca, 1'b1);
    clr;
    chk("clip_a", ca, 1'b0);
  endtask

  task t_clip40;
    ctl = 16'h00D0;
    op(1'b0, 1'b0, 1'b1, 40'h7F_FFFF_FFFF);
    op(1'b0, 1'b0, 1'b0, 40'h00_0000_0001);
    chk("acc_a", acc_a, 40'h7F_FFFF_FFFF);
    chk("clip_a", ca, 1'b1);
    op(1'b1, 1'b0, 1'b1, 40'h80_0000_0000);
    chk("guard_b", gb, 1'b1);
    gte_b = 1'b1;
    @(negedge clk);
    chk("trap", trap, 1'b1);
    gte_b = 1'b0;
    op(1'b1, 1'b1, 1'b0, 40'h00_0000_0001);
    chk("acc_b", acc_b, 40'h80_0000_0000);
    chk("clip_b", cb, 1'b1);
    op(1'b1, 1'b0, 1'b1, 40'h00_0000_0005);
    op(1'b1, 1'b1, 1'b0, 40'h00_0000_0003);
    chk("acc_b", acc_b, 40'h00_0000_0002);
    chk("acc_a", acc_a, 40'h7F_FFFF_FFFF);
    clr;
  endtask

  task t_clip32;
    ctl = 16'h0080;
    op(1'b0, 1'b0, 1'b1, 40'h00_7FFF_FFFF);
    op(1'b0, 1'b0, 1'b0, 40'h00_0000_0001);
    chk("acc_a", acc_a, 40'h00_7FFF_FFFF);
    chk("clip_a", ca, 1'b1);
    chk("guard_a", ga, 1'b0);
    clr;
    op(1'b0, 1'b0, 1'b1, 40'hFF_8000_0000);
    op(1'b0, 1'b1, 1'b0, 40'h00_0000_0001);
    chk("acc_a", acc_a, 40'hFF_8000_0000);
    op(1'b1, 1'b0, 1'b1, 40'h7F_FFFF_FFFF);
    op(1'b1, 1'b0, 1'b0, 40'h00_0000_0001);
    chk("acc_b", acc_b, 40'h80_0000_0000);
    chk("clip_b", cb, 1'b1);
    ctl = 16'h0040;
    op(1'b1, 1'b0, 1'b1, 40'h00_7FFF_FFFF);
    op(1'b1, 1'b0, 1'b0, 40'h00_0000_0001);
    chk("acc_b", acc_b, 40'h00_7FFF_FFFF);
    chk("guard_b", gb, 1'b0);
    clr;
  endtask

  task automatic rc(input logic [39:0] v, input logic [15:0] c, input logic r,
    input logic [15:0] e);
    ctl = c;
    op(1'b0, 1'b0, 1'b1, v);
    st(r, 16'h0020);
    chk("store_valid", wr_v, 1'b1);
    chk("store_data", wr_data, e);
  endtask

  task t_round;
    s_b = 1'b0;
    rc(40'h00_1234_8000, 16'h0000, 1'b0, 16'h1234);
    rc(40'h00_1234_8000, 16'h0000, 1'b1, 16'h1235);
    rc(40'h00_1235_7FFF, 16'h0000, 1'b1, 16'h1235);
    rc(40'h00_1234_8000, 16'h0002, 1'b1, 16'h1234);
    rc(40'h00_1235_8000, 16'h0002, 1'b1, 16'h1236);
    rc(40'h00_1234_8001, 16'h0002, 1'b1, 16'h1235);
    rc(40'h00_7FFF_8000, 16'h0020, 1'b1, 16'h7FFF);
    rc(40'h00_8000_0000, 16'h0020, 1'b0, 16'h7FFF);
    rc(40'h00_8000_0000, 16'h0000, 1'b0, 16'h8000);
    rc(40'hFF_8000_0000, 16'h0020, 1'b0, 16'h8000);
    rc(40'hFF_7FFF_0000, 16'h0020, 1'b0, 16'h8000);
    chk("acc_a", acc_a, 40'hFF_7FFF_0000);
    rc(40'hFF_7FFF_0000, 16'h0000, 1'b0, 16'h7FFF);
    chk("store_addr", wr_addr, 16'h0020);
    @(negedge clk);
    chk("store_valid", wr_v, 1'b0);
    s_b = 1'b1;
    st(1'b1, 16'h0022);
    chk("store_b_data", wr_data, 16'h8000);
  endtask

  task t_wb;
    ctl = 16'h0000;
    rd_addr = 16'h0100;
    op(1'b1, 1'b0, 1'b1, 40'h00_4321_8000);
    kind = 3'h1;
    op_wb = 1'b1;
    op(1'b0, 1'b0, 1'b1, 40'h00_0000_0007);
    chk("ptr", ptr, 16'h4322);
    p_data = 16'h0100;
    p_ld = 1'b1;
    @(negedge clk);
    p_ld = 1'b0;
    op_ind = 1'b1;
    op(1'b0, 1'b0, 1'b0, 40'h00_0000_0001);
    chk("wb_valid", wr_v, 1'b1);
    chk("wb_addr", wr_addr, 16'h0100);
    chk("wb_data", wr_data, 16'h4322);
    chk("ptr", ptr, 16'h0102);
    for (int k = 2; k < 6; k++)
    begin
      kind = k[2:0];
      op(1'b0, 1'b0, 1'b0, 40'h00_0000_0001);
      chk("wb_valid", wr_v, 1'b0);
    end
    chk("ptr", ptr, 16'h0102);
    kind = 3'h0;
    op_ind = 1'b0;
    op_wb = 1'b0;
  endtask

  task automatic sh(input logic [1:0] src, input logic [5:0] amt, input logic ar,
    input logic [39:0] e, input logic [15:0] em);
    @(negedge clk);
    sh_src = src;
    sh_amt = amt;
    sh_ar = ar;
    sh_v = 1'b1;
    @(negedge clk);
    sh_v = 1'b0;
    chk("shift_valid", sh_ov, 1'b1);
    chk("shift_result", sh_res, e);
    chk("shift_mcu", mcu, em);
  endtask

  task t_shift;
    chk("mem_word", xrd, 16'h4322);
    sh(2'h2, 6'h04, 1'b1, 40'h00_0432_2000, 16'h0432);
    sh(2'h2, 6'h3C, 1'b1, 40'h00_0004_3220, 16'h3220);
    op(1'b0, 1'b0, 1'b1, 40'h80_0000_0000);
    sh(2'h0, 6'h0F, 1'b1, 40'hFF_FF00_0000, 16'hFF00);
    sh(2'h0, 6'h0F, 1'b0, 40'h00_0100_0000, 16'h0100);
    sh(2'h0, 6'h00, 1'b1, 40'h80_0000_0000, 16'h0000);
    sh(2'h1, 6'h30, 1'b1, 40'h21_8000_0000, 16'h0000);
  endtask

  initial
  begin
    {op_v, op_tb, op_sub, op_zero, op_wb, op_ind, s_v, s_b, s_r} = '0;
    {gte_a, gte_b, cte, clr_a, clr_b, p_ld, sh_v, sh_ar} = '0;
    {ctl, s_addr, p_data, rd_addr, kind, sh_src, sh_amt, opd} = '0;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_catas;
    t_clip40;
    t_clip32;
    t_round;
    t_wb;
    t_shift;
    end_sim;
  end
endmodule
`default_nettype wire
